// ==== rtl/pwmrs_pkg.sv ====
// Package for the pulse-width modulator timing core: widths, reset values,
// prescale encodings and timing counts.
// Assumes a single 40 MHz system clock; no software-visible register map.
package pwmrs_pkg;

    localparam int unsigned PERIOD_W      = 8;
    localparam int unsigned DUTY_W        = 10;
    localparam int unsigned RES_W         = 4;
    localparam int unsigned PRESC_W       = 2;
    localparam int unsigned QDIV_W        = 2;
    localparam int unsigned PCNT_W        = 6;

    // Reset values of the modulator registers
    localparam logic [7:0] PERIOD_RST     = 8'hFF;
    localparam logic [9:0] DUTY_RST       = 10'h000;
    localparam logic [7:0] COUNT_RST      = 8'h00;
    localparam logic [1:0] PRESC_RST      = 2'h0;

    // Timer ticks once per four system clocks times the prescale
    localparam logic [1:0] QDIV_LAST      = 2'h3;
    localparam logic [1:0] PRESC_1        = 2'h0;
    localparam logic [1:0] PRESC_4        = 2'h1;
    localparam logic [1:0] PRESC_16       = 2'h2;
    localparam logic [1:0] PRESC_64       = 2'h3;
    localparam logic [5:0] PLAST_1        = 6'h00;
    localparam logic [5:0] PLAST_4        = 6'h03;
    localparam logic [5:0] PLAST_16       = 6'h0F;
    localparam logic [5:0] PLAST_64       = 6'h3F;

    // Resolution figures
    localparam logic [3:0] RES_MAX        = 4'hA;
    localparam logic [3:0] RES_LOG4       = 4'h2;
    localparam int unsigned STEPS_10BIT   = 1024;
    localparam int unsigned STEPS_8BIT    = 256;

    // System clock figures
    localparam int unsigned CLK_HZ        = 40000000;

endpackage

// ==== rtl/pwmrs_tick.sv ====
// Tick divider for the period timer: one pulse per 4 x prescale clocks.
// Assumes prescale changes only while stopped; a change mid-count takes
// effect at once, since the prescale counter is compared with the new last count.
module pwmrs_tick
(
    input  wire logic                          ref_clk_i,
    input  wire logic                          rst_n_i,
    input  wire logic                          run_i,
    input  wire logic [pwmrs_pkg::PRESC_W-1:0] presc_sel_i,
    output logic                               tick_o
);
    import pwmrs_pkg::*;

    logic [QDIV_W-1:0] qdiv_r;
    logic [PCNT_W-1:0] pcnt_r;
    logic [PCNT_W-1:0] plast;

    // Map prescale select onto the last count of the prescaler
    always_comb
    begin
        case (presc_sel_i)
            PRESC_1:  plast = PLAST_1;
            PRESC_4:  plast = PLAST_4;
            PRESC_16: plast = PLAST_16;
            PRESC_64: plast = PLAST_64;
            default:  plast = PLAST_1;
        endcase
    end

    // Divide by four; counters freeze when not running so a wake resumes
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            qdiv_r <= '0;
        else if (run_i)
            qdiv_r <= qdiv_r + 2'h1; // Wraps at four on purpose
    end

    // Prescaler counts quarter-rate edges
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            pcnt_r <= '0;
        else if (run_i && qdiv_r == QDIV_LAST)
        begin
            if (pcnt_r >= plast)
                pcnt_r <= '0;
            else
                pcnt_r <= pcnt_r + 6'h01;
        end
    end

    assign tick_o = run_i && (qdiv_r == QDIV_LAST) && (pcnt_r >= plast);

endmodule

// ==== rtl/pwmrs_core.sv ====
// Timing core of a pulse-width modulator: 8-bit period timer, 10-bit duty
// compare, sleep hold and reset behaviour.
// Assumes all inputs synchronous to ref_clk_i; settings are plain ports.
module pwmrs_core
(
    input  wire logic                           ref_clk_i,
    input  wire logic                           rst_n_i,
    input  wire logic                           enable_i,
    input  wire logic                           sleep_i,
    input  wire logic                           load_i,
    input  wire logic [pwmrs_pkg::PERIOD_W-1:0] period_limit_i,
    input  wire logic [pwmrs_pkg::DUTY_W-1:0]   duty_i,
    input  wire logic [pwmrs_pkg::PRESC_W-1:0]  presc_sel_i,
    output logic                                modulated_output_pin_o,
    output logic                                modulated_output_pin_oe_o,
    output logic [pwmrs_pkg::PERIOD_W-1:0]      period_timer_count_o,
    output logic [pwmrs_pkg::RES_W-1:0]         resolution_bits_o,
    output logic                                period_wrap_o
);
    import pwmrs_pkg::*;

    typedef enum logic [2:0]
    {
        PWMRS_IDLE  = 3'b001,
        PWMRS_RUN   = 3'b010,
        PWMRS_SLEEP = 3'b100
    } pwmrs_state_t;

    pwmrs_state_t          state_r;
    pwmrs_state_t          state_nxt;
    logic [PERIOD_W-1:0]   period_limit_register_r;
    logic [DUTY_W-1:0]     duty_r;
    logic [PRESC_W-1:0]    presc_r;
    logic [PERIOD_W-1:0]   period_timer_count_r;
    logic [QDIV_W-1:0]     phase_r;
    logic                  out_r;
    logic                  oe_r;
    logic                  wrap_r;
    logic                  tick;
    logic                  run;
    logic                  qtick;
    logic [DUTY_W-1:0]     fine_pos;
    logic [DUTY_W:0]       span;

    // Resolution in bits: log2(4 * (limit + 1)) rounded down
    function automatic logic [RES_W-1:0] res_bits(input logic [7:0] lim);
        logic [RES_W-1:0] r;
        r = 4'h0;
        for (int i = 0; i < PERIOD_W; i++)
            if (lim[i])
                r = 4'(i + 1);
        // All-ones limit is an exact power of two; others round down
        if (lim != 8'h00 && (lim & (lim + 8'h01)) != 8'h00)
            r = r - 4'h1;
        return r + RES_LOG4;
    endfunction

    // Sleep freezes everything, so the divider only runs while active
    assign run = (state_r == PWMRS_RUN);

    pwmrs_tick u_tick
    (
        .ref_clk_i   (ref_clk_i),
        .rst_n_i     (rst_n_i),
        .run_i       (run),
        .presc_sel_i (presc_r),
        .tick_o      (tick)
    );

    // Mode sequencing; sleep takes priority over a disable
    always_comb
    begin
        case (state_r)
            PWMRS_IDLE:
                state_nxt = (enable_i && !sleep_i) ? PWMRS_RUN : PWMRS_IDLE;
            PWMRS_RUN:
                state_nxt = sleep_i ? PWMRS_SLEEP :
                            (enable_i ? PWMRS_RUN : PWMRS_IDLE);
            PWMRS_SLEEP:
                state_nxt = sleep_i ? PWMRS_SLEEP :
                            (enable_i ? PWMRS_RUN : PWMRS_IDLE);
            default:
                state_nxt = PWMRS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            state_r <= PWMRS_IDLE;
        else
            state_r <= state_nxt;
    end

    // Settings load only outside sleep; no state changes while asleep
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            period_limit_register_r <= PERIOD_RST;
            duty_r                  <= DUTY_RST;
            presc_r                 <= PRESC_RST;
        end
        else if (load_i && !sleep_i && state_r != PWMRS_SLEEP)
        begin
            period_limit_register_r <= period_limit_i;
            duty_r                  <= duty_i;
            presc_r                 <= presc_sel_i;
        end
    end

    // Sub-step phase within one timer count, advanced once per system clock
    // and held at 3 until the next tick; this gives the two extra duty bits below the timer count.
    assign qtick = run && (tick || phase_r != QDIV_LAST);

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            phase_r <= '0;
        else if (run && tick)
            phase_r <= '0;
        else if (qtick)
            phase_r <= phase_r + 2'h1;
    end

    // Period timer: tick-driven, wraps after matching the limit
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            period_timer_count_r <= COUNT_RST;
        else if (tick)
        begin
            if (period_timer_count_r == period_limit_register_r)
                period_timer_count_r <= '0;
            else
                period_timer_count_r <= period_timer_count_r + 8'h01;
        end
        // Otherwise held, which covers sleep and resume
    end

    // Wrap pulse marks the start of a new period
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            wrap_r <= 1'b0;
        else
            wrap_r <= tick &&
                      (period_timer_count_r == period_limit_register_r);
    end

    // Fine position in the 10-bit duty space: count * 4 + phase
    assign fine_pos = {period_timer_count_r, phase_r};
    assign span     = {1'b0, period_limit_register_r, 2'h3} + 11'h001;

    // Output: high while fine position below duty; an over-long duty
    // leaves the pin untouched rather than toggling it each period.
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            out_r <= 1'b0;
        else if (run && ({1'b0, duty_r} <= span))
            out_r <= (fine_pos < duty_r);
        // Sleep or over-long duty: level kept
    end

    // Pin direction: input after reset, driven once running, kept in sleep
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            oe_r <= 1'b0;
        else if (state_r == PWMRS_RUN)
            oe_r <= 1'b1;
        else if (state_r == PWMRS_IDLE)
            oe_r <= 1'b0;
        // Sleep: direction held
    end

    // Resolution report, registered so it settles with the limit
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            resolution_bits_o <= RES_MAX;
        else
            resolution_bits_o <= res_bits(period_limit_register_r);
    end

    assign modulated_output_pin_o    = out_r;
    assign modulated_output_pin_oe_o = oe_r;
    assign period_timer_count_o      = period_timer_count_r;
    assign period_wrap_o             = wrap_r;

    // Timer must not move while asleep
    sleep_hold_a: assert property
        (@(posedge ref_clk_i) disable iff (!rst_n_i)
        state_r == PWMRS_SLEEP && $past(state_r == PWMRS_SLEEP)
        |-> $stable(period_timer_count_r))
        else $error("timer moved in sleep");

    // Pin level and direction held through sleep
    sleep_pin_a: assert property
        (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $past(state_r == PWMRS_SLEEP) && state_r == PWMRS_SLEEP
        |-> $stable(out_r) && $stable(oe_r))
        else $error("pin changed in sleep");

    // Wake keeps the count that sleep froze
    wake_resume_a: assert property
        (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $past(state_r) == PWMRS_SLEEP && state_r == PWMRS_RUN
        |-> period_timer_count_r == $past(period_timer_count_r))
        else $error("timer lost on wake");

    // Match on the limit wraps the timer and flags a new period
    wrap_zero_a: assert property
        (@(posedge ref_clk_i) disable iff (!rst_n_i)
        tick && period_timer_count_r == period_limit_register_r
        |=> period_timer_count_r == 8'h00 && wrap_r)
        else $error("timer did not wrap");

    // Ticks never closer than four system clocks
    tick_rate_a: assert property
        (@(posedge ref_clk_i) disable iff (!rst_n_i)
        tick |=> !tick [*3])
        else $error("timer ticks too fast");

    // Over-long duty freezes the pin
    long_duty_a: assert property
        (@(posedge ref_clk_i) disable iff (!rst_n_i)
        {1'b0, duty_r} > span |=> $stable(out_r))
        else $error("pin toggled with long duty");

    // Resolution report follows the stored limit one cycle later
    max_res_a: assert property
        (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $past(period_limit_register_r) == 8'hFF
        |-> resolution_bits_o == RES_MAX)
        else $error("max resolution wrong");

    res_eight_a: assert property
        (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $past(period_limit_register_r) == 8'h3F
        |-> resolution_bits_o == 4'h8)
        else $error("resolution formula wrong");

    // Pin released when reset lets go
    reset_dir_a: assert property
        (@(posedge ref_clk_i)
        $rose(rst_n_i) |-> !oe_r)
        else $error("pin driven after reset");

    wrap_c:  cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        wrap_r);
    sleep_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        state_r == PWMRS_SLEEP ##1 state_r == PWMRS_RUN);
    long_c:  cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        run && ({1'b0, duty_r} > span));
    high_c:  cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(out_r));

endmodule

// ==== dv/pwmrs_load.sv ====
// External load on the modulated pin, resolved with a weak pull-down.
// Assumes pin level and drive enable come straight from the core.
module pwmrs_load
(
    input  wire logic pin_i,
    input  wire logic oe_i,
    output logic      wire_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // A released pin falls to the pull-down, never to the last level
    assign wire_o = oe_i ? pin_i : 1'b0;
endmodule

// ==== dv/pwmrs_core_test.sv ====
// Self-checking bench for the modulator timing core.
// Assumes the core's own assertions sit in the design files.
module pwmrs_core_test;
    timeunit 1ns;
    timeprecision 100ps;
    import pwmrs_pkg::*;

    logic       ref_clk_i      = 1'b0;
    logic       rst_n_i        = 1'b0;
    logic       enable_i       = 1'b0;
    logic       sleep_i        = 1'b0;
    logic       load_i         = 1'b0;
    logic [7:0] period_limit_i = 8'h00;
    logic [9:0] duty_i         = 10'h000;
    logic [1:0] presc_sel_i    = 2'h0;
    logic       pin;
    logic       oe;
    logic [7:0] cnt;
    logic [3:0] res;
    logic       wrap;
    logic       load_lvl;
    int         error_cnt      = 0;
    int         n_compared     = 0;

    pwmrs_core i_pwmrs_core
    (
        .ref_clk_i                 (ref_clk_i),
        .rst_n_i                   (rst_n_i),
        .enable_i                  (enable_i),
        .sleep_i                   (sleep_i),
        .load_i                    (load_i),
        .period_limit_i            (period_limit_i),
        .duty_i                    (duty_i),
        .presc_sel_i               (presc_sel_i),
        .modulated_output_pin_o    (pin),
        .modulated_output_pin_oe_o (oe),
        .period_timer_count_o      (cnt),
        .resolution_bits_o         (res),
        .period_wrap_o             (wrap)
    );

    pwmrs_load i_pwmrs_load
    (
        .pin_i  (pin),
        .oe_i   (oe),
        .wire_o (load_lvl)
    );

    // 40 MHz system clock
    always #12.5 ref_clk_i = ~ref_clk_i;

    task automatic print_verdict();
        $display("compared=%0d mismatches=%0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    // Inputs always move 2 ns after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_i);
        #2;
    endtask

    task automatic cfg(input logic [7:0] l, input logic [9:0] d,
                       input logic [1:0] p);
        enable_i = 1'b1;
        period_limit_i = l;
        duty_i = d;
        presc_sel_i = p;
        load_i = 1'b1;
        step(1);
        load_i = 1'b0;
    endtask

    // Bounded wait for a wrap pulse; returns cycles waited
    task automatic wait_wrap(output int cyc);
        cyc = 0;
        while (wrap !== 1'b1)
        begin
            step(1);
            cyc++;
            if (cyc > 3000)
            begin
                error_cnt++;
                print_verdict();
            end
        end
        step(1);
    endtask

    task automatic test_reset();
        check(oe, 1'b0);
        check(load_lvl, 1'b0);
        check(cnt, COUNT_RST);
        check(res, RES_MAX);
        check(wrap, 1'b0);
        $display("test_reset done");
    endtask

    task automatic test_res();
        logic [7:0] lim[6] = '{8'hFF, 8'h3F, 8'h1F, 8'h17, 8'h0C, 8'h00};
        logic [3:0] exp[6] = '{4'hA, 4'h8, 4'h7, 4'h6, 4'h5, 4'h2};
        for (int i = 0; i < 6; i++)
        begin
            cfg(lim[i], 10'h000, PRESC_1);
            step(2);
            check(res, exp[i]);
        end
        $display("test_res done");
    endtask

    // Wrap spacing follows 4 x prescale x (limit+1) system clocks
    task automatic test_period();
        int         c;
        logic [7:0] mul[4] = '{8'h01, 8'h04, 8'h10, 8'h40};
        for (int p = 0; p < 4; p++)
        begin
            enable_i = 1'b0;
            step(2);
            cfg(8'h03, 10'h000, p[1:0]);
            wait_wrap(c);
            wait_wrap(c);
            check(c + 1, 16 * mul[p]);
        end
        $display("test_period done");
    endtask

    task automatic test_duty();
        int         c;
        int         hi;
        logic [9:0] d[3] = '{10'h000, 10'h008, 10'h010};
        for (int i = 0; i < 3; i++)
        begin
            cfg(8'h03, d[i], PRESC_1);
            wait_wrap(c);
            hi = 0;
            for (int k = 0; k < 16; k++)
            begin
                hi += int'(pin === 1'b1);
                step(1);
            end
            check(hi, d[i]);
        end
        // Width beyond the period must freeze the pin where it was; it is
        // loaded in the low half of a period, so a pin that keeps comparing
        // would go high and be caught
        cfg(8'h03, 10'h008, PRESC_1);
        wait_wrap(c);
        step(9);
        cfg(8'h03, 10'h011, PRESC_1);
        step(2);
        for (int k = 0; k < 40; k++)
        begin
            check(pin, 1'b0);
            step(1);
        end
        $display("test_duty done");
    endtask

    // Reset in mid-run must release the pin and restore every output
    task automatic test_rerun();
        cfg(8'h3F, 10'h080, PRESC_4);
        step(40);
        rst_n_i = 1'b0;
        step(2);
        rst_n_i = 1'b1;
        check(oe, 1'b0);
        check(load_lvl, 1'b0);
        check(pin, 1'b0);
        check(cnt, COUNT_RST);
        check(wrap, 1'b0);
        check(res, RES_MAX);
        step(20);
        check(oe, 1'b1);
        check(res, RES_MAX);
        check(pin, 1'b0);
        $display("test_rerun done");
    endtask

    task automatic test_sleep();
        logic [7:0] c;
        logic       p;
        cfg(8'hFF, 10'h200, PRESC_1);
        step(30);
        sleep_i = 1'b1;
        step(1);
        c = cnt;
        p = pin;
        // A load while asleep must be ignored
        period_limit_i = 8'h10;
        load_i = 1'b1;
        for (int k = 0; k < 50; k++)
        begin
            check(cnt, c);
            check(load_lvl, p);
            check(oe, 1'b1);
            step(1);
        end
        load_i = 1'b0;
        sleep_i = 1'b0;
        for (int k = 0; k < 8 && cnt === c; k++)
            step(1);
        check(cnt, c + 8'h01);
        check(res, RES_MAX);
        $display("test_sleep done");
    endtask

    initial
    begin
        step(4);
        rst_n_i = 1'b1;
        test_reset();
        test_res();
        test_period();
        test_duty();
        test_sleep();
        test_rerun();
        print_verdict();
    end
endmodule
